// ===== shared/monitor_consts.svh
// constants for the monitor configuration and interrupt register group
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (address pointer values)
// ----------------------------------------------------------------------
`define OFS_MONITOR_CONFIGURATION 8'h40
`define OFS_IRQ_STATUS_ONE        8'h41
`define OFS_IRQ_STATUS_TWO        8'h42
`define OFS_IRQ_MASK_ONE          8'h43
`define OFS_IRQ_MASK_TWO          8'h44
`define OFS_INTRUSION_CLEAR       8'h46

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_MONITOR_CONFIGURATION 8'h08
`define RST_IRQ_STATUS            8'h08
`define RST_IRQ_MASK              8'h08
`define RST_INTRUSION_CLEAR       8'h08

// ----------------------------------------------------------------------
// configuration field positions
// ----------------------------------------------------------------------
`define CFG_RUN_BIT       0
`define CFG_IRQ_EN_BIT    1
`define CFG_IRQ_HOLD_BIT  3
`define CFG_RESET_BIT     4
`define CFG_INTRUDE_BIT   6
`define CFG_INIT_BIT      7

// ----------------------------------------------------------------------
// status and mask field positions
// ----------------------------------------------------------------------
`define ST1_TEMP_BIT      4
`define ST1_FAN_ONE_BIT   6
`define ST1_FAN_TWO_BIT   7
`define ST2_INTRUDE_BIT   4
`define ST2_TEMP_LOW_BIT  7
`define MSK2_RESET_EN_BIT 7
`define ICLR_PULSE_BIT    7
// implemented status bits; reserved ones read zero
`define ST1_USED_MASK     8'hdf
`define ST2_USED_MASK     8'h93

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS     5000
`define PULSE_TIME_MS     20
// least time, rounded up
`define PULSE_CYCLES (32'((`PULSE_TIME_MS * 64'd1000000000 \
    + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))

`endif

// ===== shared/monitor_pkg.sv
// types for the monitor configuration and interrupt register group
package monitor_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        ACC_IDLE  = 2'b00,
        ACC_WRITE = 2'b01,
        ACC_READ  = 2'b10
    } access_t;
endpackage

// ===== hw/low_pulse_timer.sv
// one-shot low pulse timer for an open-drain pin
`timescale 1ns/1ps
module low_pulse_timer #(
    parameter int unsigned CYCLES = 4000000
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    logic [31:0] count_reg;  // cycles left in the pulse

    // load on start, count down to zero; done pulses in the cycle after the last busy one
    always_ff @(posedge CLK) begin
        if (RST) begin
            count_reg <= 32'h0;
            done      <= 1'b0;
        end else begin
            done <= (count_reg == 32'h1);
            // a start still high in the cycle after the pulse ends is the
            // command bit clearing itself; it must not fire a second pulse
            if (start && count_reg == 32'h0 && !done) begin
                count_reg <= CYCLES[31:0];
            end else if (count_reg != 32'h0) begin
                count_reg <= count_reg - 32'h1;
            end
        end
    end

    assign busy = (count_reg != 32'h0);
endmodule // low_pulse_timer

// ===== hw/monitor_config_and_irq_regs.sv
// configuration and interrupt register group of a hardware monitor
// ----------------------------------------------------------------------
// Overview of operation
// - run bit one scans, zero standby
// - start enables scanning and limit comparison
// - clearing run bit keeps interrupt asserted
// - enable bit gates interrupt pin
// - hold bit deasserts pin, status kept
// - hold bit pauses monitoring loop
// - reset command pulses pin low 20ms, self-clears
// - reset command needs mask two bit seven
// - intrusion command pulses pin low 20ms
// - intrusion command shared with clear register
// - init bit restores defaults, reads zero
// - voltage crossings latch status bits
// - high temperature sets status one bit four
// - fan limits set status bits six, seven
// - intrusion high sets status two bit four
// - low temperature flag only in extended mode
// - mask one blocks matching interrupt, flag kept
// - status read returns then clears
// - extended enable gates low-temperature flag
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`include "monitor_consts.svh"
module monitor_config_and_irq_regs #(
    parameter int unsigned PULSE_CYCLES = `PULSE_CYCLES
) (
    // clock and reset
    input  wire logic           CLK,
    input  wire logic           RST,
    // register port from the serial front end
    input  wire logic           REG_WR,
    input  wire logic           REG_RD,
    input  wire monitor_pkg::byte_t REG_ADDR,
    input  wire monitor_pkg::byte_t REG_WDATA,
    output monitor_pkg::byte_t  REG_RDATA,
    output logic                REG_HIT,
    // limit events from the monitoring loop (one-cycle pulses)
    input  wire logic           RAIL_2V5_INPUT,
    input  wire logic           CORE_RAIL_ONE,
    input  wire logic           RAIL_3V3_INPUT,
    input  wire logic           RAIL_5V_INPUT,
    input  wire logic           TEMP_HIGH,
    input  wire logic           TEMP_HIGH_HYSTERESIS,
    input  wire logic           FAN_ONE_FLAG,
    input  wire logic           FAN_TWO_FLAG,
    input  wire logic           RAIL_12V_INPUT,
    input  wire logic           CORE_RAIL_TWO,
    input  wire logic           TEMP_LOW_FLAG,
    // extended mode enable from the extended register block
    input  wire logic           EXT_MODE_EN,
    // chassis intrusion pin (open drain)
    input  wire logic           CHASSIS_INTRUSION_IN,
    output logic                CHASSIS_INTRUSION_OUT,
    output logic                CHASSIS_INTRUSION_OE_N,
    // reset pin drive (open drain)
    output logic                RESET_PIN_OUT,
    output logic                RESET_PIN_OE_N,
    // monitoring loop control and interrupt
    output logic                SCAN_RUN,
    output logic                INIT_PULSE,
    output logic                IRQ_N
);
    import monitor_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    byte_t cfg_reg, cfg_next;        // configuration
    byte_t st1_reg, st1_next;        // status one
    byte_t st2_reg, st2_next;        // status two
    byte_t msk1_reg, msk1_next;      // mask one
    byte_t msk2_reg, msk2_next;      // mask two
    byte_t iclr_reg, iclr_next;      // intrusion clear, bits 6:0 plain
    logic  ipulse_reg, ipulse_next;  // shared intrusion pulse command
    logic  [2:0] ci_sync_reg;        // intrusion pin synchroniser
    logic  ci_level_reg;             // filtered intrusion level
    access_t acc;                    // decoded access kind

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire hit_cfg  = (REG_ADDR == `OFS_MONITOR_CONFIGURATION);
    wire hit_st1  = (REG_ADDR == `OFS_IRQ_STATUS_ONE);
    wire hit_st2  = (REG_ADDR == `OFS_IRQ_STATUS_TWO);
    wire hit_msk1 = (REG_ADDR == `OFS_IRQ_MASK_ONE);
    wire hit_msk2 = (REG_ADDR == `OFS_IRQ_MASK_TWO);
    wire hit_iclr = (REG_ADDR == `OFS_INTRUSION_CLEAR);
    wire hit_any  = hit_cfg | hit_st1 | hit_st2 | hit_msk1 | hit_msk2
                  | hit_iclr;
    // write wins if both strobes arrive together
    assign acc = REG_WR ? ACC_WRITE : (REG_RD ? ACC_READ : ACC_IDLE);
    wire wr   = (acc == ACC_WRITE);
    wire rd   = (acc == ACC_READ);

    // software initialization: writing one to init restores defaults
    wire init_cmd = wr & hit_cfg & REG_WDATA[`CFG_INIT_BIT];

    // ------------------------------------------------------------------
    // pulse timers
    // ------------------------------------------------------------------
    logic rst_busy, rst_done, ci_busy, ci_done;
    // reset pulse only starts while mask two bit seven enables it
    wire rst_start = cfg_reg[`CFG_RESET_BIT]
                   & msk2_reg[`MSK2_RESET_EN_BIT];
    wire ci_start  = ipulse_reg;

    low_pulse_timer #(.CYCLES(PULSE_CYCLES)) u_reset_timer (
        .CLK   (CLK),
        .RST   (RST),
        .start (rst_start),
        .busy  (rst_busy),
        .done  (rst_done)
    );

    low_pulse_timer #(.CYCLES(PULSE_CYCLES)) u_intrusion_timer (
        .CLK   (CLK),
        .RST   (RST),
        .start (ci_start),
        .busy  (ci_busy),
        .done  (ci_done)
    );

    // ------------------------------------------------------------------
    // event collection
    // ------------------------------------------------------------------
    // intrusion input seen once sync stages two and three agree high;
    // our own low drive must not count as an event
    wire ci_rise = ci_sync_reg[1] & ci_sync_reg[2] & ~ci_level_reg
                 & ~ci_busy;
    // events only while the loop actually runs, except the intrusion input
    wire loop_on = SCAN_RUN;
    byte_t ev1, ev2;
    assign ev1 = loop_on ? {FAN_TWO_FLAG, FAN_ONE_FLAG,
                            1'b0,
                            TEMP_HIGH | TEMP_HIGH_HYSTERESIS,
                            RAIL_5V_INPUT, RAIL_3V3_INPUT,
                            CORE_RAIL_ONE, RAIL_2V5_INPUT}
                         : 8'h00;
    assign ev2 = {TEMP_LOW_FLAG & EXT_MODE_EN & loop_on,
                  2'b00,
                  ci_rise,
                  2'b00,
                  loop_on & CORE_RAIL_TWO,
                  loop_on & RAIL_12V_INPUT};

    // ------------------------------------------------------------------
    // next-state for status: read clears, new event wins over clear
    // ------------------------------------------------------------------
    assign st1_next = init_cmd ? `RST_IRQ_STATUS
                    : (((rd & hit_st1) ? 8'h00 : st1_reg) | ev1);
    assign st2_next = init_cmd ? `RST_IRQ_STATUS
                    : (((rd & hit_st2) ? 8'h00 : st2_reg) | ev2);

    // ------------------------------------------------------------------
    // next-state for mask and configuration
    // ------------------------------------------------------------------
    assign msk1_next = init_cmd ? `RST_IRQ_MASK
                     : ((wr & hit_msk1) ? REG_WDATA : msk1_reg);
    assign msk2_next = init_cmd ? `RST_IRQ_MASK
                     : ((wr & hit_msk2) ? REG_WDATA : msk2_reg);

    // configuration: init and intrusion-command bits are not kept here
    byte_t cfg_wr;
    assign cfg_wr = {1'b0, 1'b0, REG_WDATA[5],
                     REG_WDATA[`CFG_RESET_BIT] | cfg_reg[`CFG_RESET_BIT],
                     REG_WDATA[3:0]};
    byte_t cfg_held;
    // reset command clears once its pulse has ended, or at once if
    // the enable in mask two is off (nothing to wait for)
    assign cfg_held = {cfg_reg[7:5],
                       cfg_reg[`CFG_RESET_BIT]
                         & ~rst_done
                         & msk2_reg[`MSK2_RESET_EN_BIT],
                       cfg_reg[3:0]};
    assign cfg_next = init_cmd ? `RST_MONITOR_CONFIGURATION
                    : ((wr & hit_cfg) ? cfg_wr : cfg_held);

    // shared intrusion pulse bit: set through either address,
    // cleared when the pulse ends
    wire ipulse_set = (wr & hit_cfg & REG_WDATA[`CFG_INTRUDE_BIT])
                    | (wr & hit_iclr & REG_WDATA[`ICLR_PULSE_BIT]);
    assign ipulse_next = init_cmd ? 1'b0
                       : (ipulse_set | (ipulse_reg & ~ci_done));
    assign iclr_next = init_cmd ? `RST_INTRUSION_CLEAR
                     : ((wr & hit_iclr) ? {1'b0, REG_WDATA[6:0]}
                                        : iclr_reg);

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    byte_t rd_mux;
    assign rd_mux =
        hit_cfg  ? {1'b0, ipulse_reg, cfg_reg[5:0]} :
        hit_st1  ? (st1_reg & `ST1_USED_MASK) :
        hit_st2  ? (st2_reg & `ST2_USED_MASK) :
        hit_msk1 ? msk1_reg :
        hit_msk2 ? msk2_reg :
        hit_iclr ? {ipulse_reg, iclr_reg[6:0]} : 8'h00;

    // ------------------------------------------------------------------
    // interrupt decision
    // ------------------------------------------------------------------
    // pending stays on when run is cleared; read, mask, init, hold or enable clear releases
    wire pend = |(st1_reg & `ST1_USED_MASK & ~msk1_reg)
              | |(st2_reg & `ST2_USED_MASK
                  & {1'b1, ~msk2_reg[6:0]});
    wire irq_next = pend & cfg_reg[`CFG_IRQ_EN_BIT]
                  & ~cfg_reg[`CFG_IRQ_HOLD_BIT];
    // scanning and limit checking run only with run set, hold clear
    wire run_next = cfg_next[`CFG_RUN_BIT]
                  & ~cfg_next[`CFG_IRQ_HOLD_BIT];

    // ------------------------------------------------------------------
    // register update
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg_reg    <= `RST_MONITOR_CONFIGURATION;
            st1_reg    <= `RST_IRQ_STATUS;
            st2_reg    <= `RST_IRQ_STATUS;
            msk1_reg   <= `RST_IRQ_MASK;
            msk2_reg   <= `RST_IRQ_MASK;
            iclr_reg   <= `RST_INTRUSION_CLEAR;
            ipulse_reg <= 1'b0;
        end else begin
            cfg_reg    <= cfg_next;
            st1_reg    <= st1_next;
            st2_reg    <= st2_next;
            msk1_reg   <= msk1_next;
            msk2_reg   <= msk2_next;
            iclr_reg   <= iclr_next;
            ipulse_reg <= ipulse_next;
        end
    end

    // intrusion pin: three stages, level moves when stages two and three agree
    always_ff @(posedge CLK) begin
        if (RST) begin
            ci_sync_reg  <= 3'b000;
            ci_level_reg <= 1'b0;
        end else begin
            ci_sync_reg <= {ci_sync_reg[1:0], CHASSIS_INTRUSION_IN};
            if (ci_sync_reg[1] == ci_sync_reg[2]) begin
                ci_level_reg <= ci_sync_reg[2];
            end
        end
    end

    // outputs, all registered
    always_ff @(posedge CLK) begin
        if (RST) begin
            REG_RDATA              <= 8'h00;
            REG_HIT                <= 1'b0;
            IRQ_N                  <= 1'b1;
            SCAN_RUN               <= 1'b0;
            INIT_PULSE             <= 1'b0;
            RESET_PIN_OUT          <= 1'b0;
            RESET_PIN_OE_N         <= 1'b1;
            CHASSIS_INTRUSION_OUT  <= 1'b0;
            CHASSIS_INTRUSION_OE_N <= 1'b1;
        end else begin
            REG_RDATA      <= rd ? rd_mux : REG_RDATA;
            REG_HIT        <= (rd | wr) & hit_any;
            IRQ_N          <= ~irq_next;
            SCAN_RUN       <= run_next;
            INIT_PULSE     <= init_cmd;
            RESET_PIN_OUT  <= 1'b0;
            // low drive only while the pulse timer runs
            RESET_PIN_OE_N <= ~(rst_busy & ~rst_done);
            CHASSIS_INTRUSION_OUT  <= 1'b0;
            CHASSIS_INTRUSION_OE_N <= ~(ci_busy & ~ci_done);
        end
    end
endmodule // monitor_config_and_irq_regs

// ===== dv/monitor_regs_sva.sv
// port-level checker for the monitor configuration and interrupt registers
`timescale 1ns/1ps
module monitor_regs_sva #(
    parameter int unsigned PULSE_CYCLES = 20
) (
    // clock and reset
    input wire logic               CLK,
    input wire logic               RST,
    // register port
    input wire logic               REG_WR,
    input wire logic               REG_RD,
    input wire monitor_pkg::byte_t REG_ADDR,
    input wire monitor_pkg::byte_t REG_WDATA,
    input wire monitor_pkg::byte_t REG_RDATA,
    input wire logic               REG_HIT,
    // pins and loop control
    input wire logic               RESET_PIN_OUT,
    input wire logic               RESET_PIN_OE_N,
    input wire logic               CHASSIS_INTRUSION_OUT,
    input wire logic               SCAN_RUN,
    input wire logic               INIT_PULSE,
    input wire logic               IRQ_N
);
    import monitor_pkg::*;
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic        en_reg;   // shadow of the reset-enable mask bit
    int unsigned lo_cnt;   // cycles the reset pin has been driven
    wire mapped = REG_ADDR inside {8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h46};
    wire cfg_wr = REG_WR && (REG_ADDR == 8'h40);
    wire rst_cmd = cfg_wr && REG_WDATA[4] && !REG_WDATA[7] && RESET_PIN_OE_N;
    // init write clears the shadow, since it restores the mask default
    always_ff @(posedge CLK) begin
        if (RST || (cfg_wr && REG_WDATA[7])) en_reg <= 1'b0;
        else if (REG_WR && REG_ADDR == 8'h44) en_reg <= REG_WDATA[7];
    end
    // counting in logic keeps the long pulse out of a repetition
    always_ff @(posedge CLK) begin
        if (RST || RESET_PIN_OE_N) lo_cnt <= 0;
        else lo_cnt <= lo_cnt + 1;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_pin_driven; !RESET_PIN_OE_N; endsequence
    sequence s_pin_idle; RESET_PIN_OE_N [*4]; endsequence
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_unmapped_read: assert property (REG_RD && !REG_WR && !mapped
        |=> !REG_HIT && REG_RDATA == 8'h00) else $error("unmapped read");
    a_mapped_hit: assert property ((REG_RD || REG_WR) && mapped
        |=> REG_HIT) else $error("mapped access without hit");
    a_hit_cause: assert property (REG_HIT |-> $past(REG_RD || REG_WR))
        else $error("hit without access");
    a_rdata_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without read");
    a_scan_follows: assert property (cfg_wr && !REG_WDATA[7]
        |-> ##2 SCAN_RUN == (REG_WDATA[0] && !REG_WDATA[3]))
        else $error("scan run wrong after config write");
    a_irq_gated: assert property (cfg_wr
        && (REG_WDATA[7] || REG_WDATA[3] || !REG_WDATA[1]) |-> ##2 IRQ_N)
        else $error("interrupt not released");
    a_init_pulse: assert property (cfg_wr && REG_WDATA[7]
        |-> ##[1:2] INIT_PULSE) else $error("init pulse missing");
    a_pins_low: assert property (!RESET_PIN_OUT
        && !CHASSIS_INTRUSION_OUT) else $error("open drain drives high");
    a_reset_start: assert property (rst_cmd && en_reg
        |-> ##[1:4] s_pin_driven) else $error("reset pulse not started");
    a_reset_refused: assert property (rst_cmd && !en_reg
        |-> ##1 s_pin_idle) else $error("reset pulse not refused");
    a_reset_length: assert property ($rose(RESET_PIN_OE_N)
        |-> lo_cnt == PULSE_CYCLES) else $error("reset pulse length");
endmodule // monitor_regs_sva

// ===== dv/monitor_pin_model.sv
// open-drain pin wiring with pull-ups and the intrusion switch
`timescale 1ns/1ps
module monitor_pin_model (
    // pin drives from the block
    input  wire logic ci_oe_n,
    input  wire logic ci_out,
    input  wire logic rst_oe_n,
    input  wire logic rst_out,
    // intrusion switch, high when the case is open
    input  wire logic sw_open,
    // resolved pin levels
    output logic      ci_wire,
    output logic      rst_wire
);
    // driver wins over the switch; the released reset pin goes to the pull-up level
    assign ci_wire  = !ci_oe_n ? ci_out : sw_open;
    assign rst_wire = !rst_oe_n ? rst_out : 1'b1;
endmodule // monitor_pin_model

// ===== dv/monitor_config_and_irq_regs_bench.sv
// self-checking bench for the monitor configuration and interrupt registers
`timescale 1ns/1ps
module monitor_config_and_irq_regs_bench;
    import monitor_pkg::*;
    localparam int PULSE = 20;  // shortened pulse count for simulation
    localparam int POS[11] = '{0, 1, 2, 3, 4, 4, 6, 7, 0, 1, 7};
    localparam byte_t ADR[6] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h46};
    localparam byte_t RV[6]  = '{8'h08, 8'h08, 8'h00, 8'h08, 8'h08, 8'h08};
    logic        clk, rst, reg_wr, reg_rd, ext_mode, sw_open, hit, h;
    logic        ci_oe_n, ci_out, rst_oe_n, rst_out, scan_run, init_p, irq_n;
    logic        ci_wire, rst_wire;
    logic [10:0] ev_v;       // one bit per limit event input
    byte_t       reg_addr, reg_wdata, rdata, d, r;
    int          error_cnt, n_compared, cyc, seed, k, n;
    monitor_config_and_irq_regs #(.PULSE_CYCLES(PULSE)) dut_u (
        .CLK(clk), .RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata),
        .REG_HIT(hit), .RAIL_2V5_INPUT(ev_v[0]), .CORE_RAIL_ONE(ev_v[1]),
        .RAIL_3V3_INPUT(ev_v[2]), .RAIL_5V_INPUT(ev_v[3]),
        .TEMP_HIGH(ev_v[4]), .TEMP_HIGH_HYSTERESIS(ev_v[5]),
        .FAN_ONE_FLAG(ev_v[6]), .FAN_TWO_FLAG(ev_v[7]),
        .RAIL_12V_INPUT(ev_v[8]), .CORE_RAIL_TWO(ev_v[9]),
        .TEMP_LOW_FLAG(ev_v[10]), .EXT_MODE_EN(ext_mode),
        .CHASSIS_INTRUSION_IN(ci_wire), .CHASSIS_INTRUSION_OUT(ci_out),
        .CHASSIS_INTRUSION_OE_N(ci_oe_n), .RESET_PIN_OUT(rst_out),
        .RESET_PIN_OE_N(rst_oe_n), .SCAN_RUN(scan_run),
        .INIT_PULSE(init_p), .IRQ_N(irq_n));
    monitor_pin_model pins_u (.ci_oe_n(ci_oe_n), .ci_out(ci_out),
        .rst_oe_n(rst_oe_n), .rst_out(rst_out), .sw_open(sw_open),
        .ci_wire(ci_wire), .rst_wire(rst_wire));
    // ------------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // the whole run needs about 300 cycles; a hang is cut well after
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            end_of_test;
        end
    end
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input byte_t seen, input byte_t exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // strobes last one cycle; the next access waits for a fresh edge
    task automatic wr(input byte_t a, input byte_t v);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input byte_t a);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
        h = hit;
    endtask
    task automatic ev(input int i);
        @(posedge clk);
        ev_v[i] <= 1'b1;
        @(posedge clk);
        ev_v <= '0;
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h84957e64; cyc = 0; error_cnt = 0; n_compared = 0;
        rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0;
        reg_wdata = '0; ev_v = '0; ext_mode = 1'b0; sw_open = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 6; k++) begin
            rd(ADR[k]);
            chk(d, RV[k], "reset value");
        end
        chk({7'h0, irq_n}, 8'h01, "irq after reset");
        rd(8'h45);
        chk({h, d[6:0]}, 8'h00, "unmapped read");
        rd(8'h41);
        chk(d, 8'h00, "status after read");
        for (k = 3; k < 5; k++) begin
            r = 8'($random(seed));
            wr(ADR[k], r);
            rd(ADR[k]);
            chk(d, r, "mask readback");
        end
        // masks are set up before the loop is started
        wr(8'h43, 8'h00);
        wr(8'h44, 8'h00);
        ext_mode <= 1'b1;
        wr(8'h40, 8'h03);
        idle(3);
        for (k = 0; k < 11; k++) begin
            ev(k); idle(3);
            chk({7'h0, irq_n}, 8'h00, "irq on flag");
            rd(k < 8 ? 8'h41 : 8'h42);
            chk(d, 8'h01 << POS[k], "status flag");
            idle(3);
            chk({7'h0, irq_n}, 8'h01, "irq after read");
        end
        @(posedge clk); ext_mode <= 1'b0;
        ev(10); idle(3); rd(8'h42);
        chk(d, 8'h00, "low temp gated");
        k = $unsigned($random(seed)) % 8;
        wr(8'h43, 8'hff); ev(k); idle(3);
        chk({7'h0, irq_n}, 8'h01, "masked flag");
        rd(8'h41);
        chk(d, 8'h01 << POS[k], "masked flag kept");
        wr(8'h43, 8'h00); ev(0); wr(8'h40, 8'h0b); idle(3);
        chk({7'h0, irq_n}, 8'h01, "hold releases irq");
        chk({7'h0, scan_run}, 8'h00, "hold stops scan");
        rd(8'h41);
        chk(d, 8'h01, "hold keeps status");
        ev(1); idle(2); rd(8'h41);
        chk(d, 8'h00, "no latch while held");
        wr(8'h40, 8'h03); idle(3);
        chk({7'h0, scan_run}, 8'h01, "scan resumes");
        ev(2); wr(8'h40, 8'h02); idle(3);
        chk({7'h0, irq_n}, 8'h00, "standby keeps irq");
        chk({7'h0, scan_run}, 8'h00, "standby");
        rd(8'h41);
        chk(d, 8'h04, "standby keeps status");
        wr(8'h40, 8'h13); idle(5);
        chk({7'h0, rst_oe_n}, 8'h01, "reset refused");
        rd(8'h40);
        chk(d, 8'h03, "refused bit clears");
        wr(8'h44, 8'h80); wr(8'h40, 8'h13);
        k = 0;
        while (rst_oe_n !== 1'b0 && k < 10) begin idle(1); k++; end
        chk({7'h0, rst_wire}, 8'h00, "reset pin low");
        n = 0;
        while (rst_oe_n === 1'b0 && n < 100) begin idle(1); n++; end
        chk(n[7:0], 8'(PULSE), "reset pulse cycles");
        rd(8'h40);
        chk(d, 8'h03, "reset bit self clears");
        wr(8'h46, 8'h80); idle(3); rd(8'h40);
        chk(d, 8'h43, "mirror in config");
        chk({7'h0, ci_oe_n}, 8'h00, "intrusion pin low");
        k = 0;
        while (ci_oe_n === 1'b0 && k < 100) begin idle(1); k++; end
        rd(8'h46);
        chk(d, 8'h00, "intrusion bit self clears");
        @(posedge clk); sw_open <= 1'b1;
        idle(8);
        chk({7'h0, irq_n}, 8'h00, "intrusion irq");
        rd(8'h42);
        chk(d, 8'h10, "intrusion flag");
        @(posedge clk); sw_open <= 1'b0;
        wr(8'h43, 8'h55); wr(8'h40, 8'h80); idle(2);
        for (k = 0; k < 6; k += 3) begin
            rd(ADR[k]);
            chk(d, 8'h08, "init restores");
        end
        end_of_test;
    end
endmodule // monitor_config_and_irq_regs_bench
bind monitor_config_and_irq_regs monitor_regs_sva #(
    .PULSE_CYCLES(PULSE_CYCLES)
) sva_u (.CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_HIT(REG_HIT), .RESET_PIN_OUT(RESET_PIN_OUT),
    .RESET_PIN_OE_N(RESET_PIN_OE_N),
    .CHASSIS_INTRUSION_OUT(CHASSIS_INTRUSION_OUT), .SCAN_RUN(SCAN_RUN),
    .INIT_PULSE(INIT_PULSE), .IRQ_N(IRQ_N));
